// File: hw/pfs_stabilizer.sv
// Clock generator frequency-change control with watchdog stabilization counter.
//
// Functional notes
// - A frequency control write halts the processor and starts the counter.
// - Counter overflow after a frequency change resumes clocks with the new settings.
// - One watchdog channel with an 8-bit up-only counter.
// - Software selects watchdog timer mode or interval timer mode.
// - In watchdog mode an overflow drives the overflow output.
// - Three-bit clock select picks peripheral clock divided by 1 to 16384.
// - With the timer enable bit at 0 the timer counts only during stabilization after a frequency change or a standby exit.
// - Keyed word write to the counter loads its low byte.
// - Software starts timer and frequency change; wake interrupt starts standby exit.
// - Clock output pin is driven only while clock output enable is 1.
// - Multiplier code 000 sets the first PLL factor to one.
// - Range select 0 places the generator in its low-frequency range.
// - Peripheral divider code 001 gives half-rate peripheral clock.
// - Internal and peripheral clock rates are set independently.
// - Sleep and standby gate clocks; module standby stops single modules.
// - Separate internal, bus and peripheral clocks are produced.
module pfs_stabilizer
  import pfs_pkg::*;
#(
  parameter int          N_MOD       = 4,
  parameter logic [3:0]  BUS_TERM    = 4'h1
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic               sleep_req,
  input  wire logic               standby_req,
  input  wire logic               wake_irq,
  input  wire logic [N_MOD-1:0]   module_stop,
  output logic                    cpu_halt,
  output logic                    internal_clk_en,
  output logic                    bus_clk_en,
  output logic                    peripheral_clk_en,
  output logic [N_MOD-1:0]        module_clk_en,
  output pfs_clk_cfg_t            clk_cfg,
  output logic                    ckio_out,
  output logic                    ckio_oe,
  output logic                    overflow_output
);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  // Every transfer takes one wait state so that read data always reflect
  // a write committed in the cycle before.
  logic              pend_reg;
  logic [31:0]       a_addr_reg;
  logic              a_wr_reg;
  logic              a_word_reg;
  logic              hreadyout_reg;
  logic [31:0]       hrdata_reg;

  wire               acc     = hsel & htrans[1] & hready;
  wire               sel_csr = a_addr_reg == WDT_CSR_ADDR;
  wire               sel_cnt = a_addr_reg == WDT_CNT_ADDR;
  wire               sel_frq = a_addr_reg == FRQ_CTL_ADDR;
  wire               wr_fire = pend_reg & a_wr_reg & a_word_reg;
  wire  [7:0]        wr_key  = hwdata[KEY_LSB +: KEY_W];
  wire               wr_csr  = wr_fire & sel_csr & (wr_key == CSR_KEY);
  wire               wr_cnt  = wr_fire & sel_cnt & (wr_key == CNT_KEY);
  wire               wr_frq  = wr_fire & sel_frq;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg      <= 1'b0;
      a_addr_reg    <= 32'h0000_0000;
      a_wr_reg      <= 1'b0;
      a_word_reg    <= 1'b0;
      hreadyout_reg <= 1'b1;
    end else if (acc) begin
      pend_reg      <= 1'b1;
      a_addr_reg    <= haddr;
      a_wr_reg      <= hwrite;
      a_word_reg    <= hsize == HSIZE_WORD;
      hreadyout_reg <= 1'b0;
    end else begin
      pend_reg      <= 1'b0;
      hreadyout_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  pfs_state_t        state_reg;
  pfs_state_t        state_next;
  logic              tme_reg;
  logic              mode_reg;
  logic              wovf_reg;
  logic              iovf_reg;
  logic [2:0]        cks_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [PRESC_W-1:0] presc_reg;
  logic [PRESC_W-1:0] presc_next;
  logic [15:0]       frq_reg;
  pfs_clk_cfg_t      cfg_reg;
  logic [N_DOM-1:0]  tick;

  wire               in_stab  = state_reg == PFS_STAB;
  wire               cnt_run  = tme_reg | in_stab;
  wire               wdt_tick = cnt_run & tick[DOM_PER]
                                & ((presc_reg & cks_mask(cks_reg)) == cks_mask(cks_reg));
  wire               ovf      = wdt_tick & (cnt_reg == CNT_MAX) & ~wr_cnt;
  wire               ovf_stab = ovf & in_stab;
  wire               ovf_tmr  = ovf & ~in_stab & tme_reg;
  wire               ovf_wdt  = ovf_tmr & mode_reg;
  wire               ovf_itv  = ovf_tmr & ~mode_reg;

  assign presc_next = cnt_run ? (tick[DOM_PER] ? presc_reg + 1'b1 : presc_reg)
                              : {PRESC_W{1'b0}};
  assign cnt_next   = wr_cnt   ? hwdata[CNT_W-1:0] :
                      wdt_tick ? cnt_reg + 1'b1 : cnt_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg   <= CNT_RESET;
      presc_reg <= {PRESC_W{1'b0}};
    end else begin
      cnt_reg   <= cnt_next;
      presc_reg <= presc_next;
    end
  end

  // Control/status: flags are set by overflow and cleared by writing 0;
  // an overflow in the same cycle as the clearing write wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tme_reg  <= 1'b0;
      mode_reg <= 1'b0;
      cks_reg  <= CKS_RESET;
      wovf_reg <= 1'b0;
      iovf_reg <= 1'b0;
    end else begin
      if (wr_csr) begin
        tme_reg  <= hwdata[CSR_TME_BIT];
        mode_reg <= hwdata[CSR_MODE_BIT];
        cks_reg  <= hwdata[CSR_CKS_LSB +: CKS_W];
      end
      wovf_reg <= ovf_wdt | (wovf_reg & ~(wr_csr & ~hwdata[CSR_WOVF_BIT]));
      iovf_reg <= ovf_itv | (iovf_reg & ~(wr_csr & ~hwdata[CSR_IOVF_BIT]));
    end
  end

  // ----------------------------------------------------------------------
  // Frequency change sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PFS_RUN: begin
        if (wr_frq) begin
          state_next = PFS_STAB;
        end else if (standby_req) begin
          state_next = PFS_STBY;
        end
      end
      PFS_STAB: begin
        if (ovf_stab) begin
          state_next = PFS_RUN;
        end
      end
      PFS_STBY: begin
        if (wake_irq) begin
          state_next = PFS_STAB;
        end
      end
    endcase
  end

  // New settings reach the clock tree only once the stabilization count ends.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= PFS_RUN;
      frq_reg   <= FRQ_RESET;
      cfg_reg   <= frq_fields(FRQ_RESET);
    end else begin
      state_reg <= state_next;
      if (wr_frq) begin
        frq_reg <= hwdata[15:0];
      end
      if (ovf_stab) begin
        cfg_reg <= frq_fields(frq_reg);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------------
  logic [DIV_W-1:0]  dom_term [N_DOM];

  assign dom_term[DOM_INT] = div_term(cfg_reg.internal_divider);
  assign dom_term[DOM_BUS] = BUS_TERM;
  assign dom_term[DOM_PER] = div_term(cfg_reg.peripheral_divider);

  for (genvar g = 0; g < N_DOM; g++) begin : g_div
    logic [DIV_W-1:0] div_reg;
    // The >= compare recovers at once when a smaller ratio is applied.
    assign tick[g] = div_reg >= dom_term[g];
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        div_reg <= {DIV_W{1'b0}};
      end else begin
        div_reg <= tick[g] ? {DIV_W{1'b0}} : div_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock gating and outputs
  // ----------------------------------------------------------------------
  // The counter itself runs from the free peripheral tick, so with the timer enable
  // bit at 1 it keeps counting while peripheral enables are gated in standby.
  logic              int_en_reg;
  logic              bus_en_reg;
  logic              per_en_reg;
  logic [N_MOD-1:0]  mod_en_reg;
  logic              halt_reg;
  logic              ckio_reg;
  logic              ckoe_reg;
  logic              wovf_out_reg;

  wire               not_stby = state_reg != PFS_STBY;
  wire               run_int  = (state_reg == PFS_RUN) & ~sleep_req;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_en_reg   <= 1'b0;
      bus_en_reg   <= 1'b0;
      per_en_reg   <= 1'b0;
      mod_en_reg   <= {N_MOD{1'b0}};
      halt_reg     <= 1'b0;
      wovf_out_reg <= 1'b0;
    end else begin
      int_en_reg   <= tick[DOM_INT] & run_int;
      bus_en_reg   <= tick[DOM_BUS] & not_stby;
      per_en_reg   <= tick[DOM_PER] & not_stby;
      mod_en_reg   <= {N_MOD{tick[DOM_PER] & not_stby}} & ~module_stop;
      halt_reg     <= state_next != PFS_RUN;
      wovf_out_reg <= ovf_wdt;
    end
  end

  // External clock pin follows the bus clock and is released when disabled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ckio_reg <= 1'b0;
      ckoe_reg <= 1'b0;
    end else begin
      ckoe_reg <= cfg_reg.clock_out_enable;
      ckio_reg <= cfg_reg.clock_out_enable & (ckio_reg ^ tick[DOM_BUS]);
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  wire  [15:0]       csr_view = {8'h00, tme_reg, mode_reg, wovf_reg, iovf_reg,
                                 1'b0, cks_reg};
  wire  [15:0]       rd_val   = sel_csr ? csr_view :
                                sel_cnt ? {8'h00, cnt_reg} :
                                sel_frq ? frq_reg : 16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (pend_reg) begin
      hrdata_reg <= {16'h0000, rd_val};
    end
  end

  assign hreadyout         = hreadyout_reg;
  assign hresp             = HRESP_OKAY;
  assign hrdata            = hrdata_reg;
  assign cpu_halt          = halt_reg;
  assign internal_clk_en   = int_en_reg;
  assign bus_clk_en        = bus_en_reg;
  assign peripheral_clk_en = per_en_reg;
  assign module_clk_en     = mod_en_reg;
  assign clk_cfg           = cfg_reg;
  assign ckio_out          = ckio_reg;
  assign ckio_oe           = ckoe_reg;
  assign overflow_output   = wovf_out_reg;

endmodule : pfs_stabilizer

// File: hw/pfs_pkg.sv
// Constants, field layouts and carrier types for the PLL frequency-change stabilizer.
package pfs_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  // Register indices; the bus byte address is four times the index.
  localparam logic [31:0] WDT_CSR_IDX  = 32'hfffe_0000;
  localparam logic [31:0] WDT_CNT_IDX  = 32'hfffe_0002;
  localparam logic [31:0] FRQ_CTL_IDX  = 32'hfffe_0010;
  localparam logic [31:0] WDT_CSR_ADDR = WDT_CSR_IDX << 2;
  localparam logic [31:0] WDT_CNT_ADDR = WDT_CNT_IDX << 2;
  localparam logic [31:0] FRQ_CTL_ADDR = FRQ_CTL_IDX << 2;

  // Write keys carried in the upper byte of the 16-bit register word.
  localparam logic [7:0]  CSR_KEY      = 8'ha5;
  localparam logic [7:0]  CNT_KEY      = 8'h5a;
  localparam int          KEY_LSB      = 8;
  localparam int          KEY_W        = 8;

  // Watchdog control/status field positions.
  localparam int          CSR_TME_BIT  = 7;
  localparam int          CSR_MODE_BIT = 6;
  localparam int          CSR_WOVF_BIT = 5;
  localparam int          CSR_IOVF_BIT = 4;
  localparam int          CSR_CKS_LSB  = 0;
  localparam int          CKS_W        = 3;

  // Frequency control field positions.
  localparam int          FRQ_FREQ_RANGE_SELECT_BIT = 12;
  localparam int          FRQ_CKOE_BIT = 11;
  localparam int          FRQ_STC_LSB  = 8;
  localparam int          FRQ_IFC_LSB  = 4;
  localparam int          FRQ_PFC_LSB  = 0;
  localparam int          FLD_W        = 3;

  // Reset values.
  localparam logic [15:0] FRQ_RESET    = 16'h120c;
  localparam logic [7:0]  CNT_RESET    = 8'h00;
  localparam logic [2:0]  CKS_RESET    = 3'h0;

  // ----------------------------------------------------------------------
  // Widths, bus codes and clock domains
  // ----------------------------------------------------------------------
  localparam int          CNT_W        = 8;
  localparam logic [7:0]  CNT_MAX      = 8'hff;
  localparam int          PRESC_W      = 14;
  localparam int          DIV_W        = 4;
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;
  localparam logic        HRESP_OKAY   = 1'b0;
  localparam int          DOM_INT      = 0;
  localparam int          DOM_BUS      = 1;
  localparam int          DOM_PER      = 2;
  localparam int          N_DOM        = 3;

  typedef enum logic [1:0] {PFS_RUN, PFS_STAB, PFS_STBY} pfs_state_t;

  // Clock settings applied to the clock tree.
  typedef struct packed {
    logic       freq_range_select;
    logic       clock_out_enable;
    logic [2:0] pll1_multiplier;
    logic [2:0] internal_divider;
    logic [2:0] peripheral_divider;
  } pfs_clk_cfg_t;

  // ----------------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------------
  // Prescaler mask: a tick passes when all masked prescaler bits are one.
  function automatic logic [PRESC_W-1:0] cks_mask(input logic [2:0] code);
    unique case (code)
      3'h0: cks_mask = 14'h0000;
      3'h1: cks_mask = 14'h003f;
      3'h2: cks_mask = 14'h007f;
      3'h3: cks_mask = 14'h00ff;
      3'h4: cks_mask = 14'h01ff;
      3'h5: cks_mask = 14'h03ff;
      3'h6: cks_mask = 14'h0fff;
      3'h7: cks_mask = 14'h3fff;
    endcase
  endfunction : cks_mask

  // Divider terminal count (ratio minus one) for a divider field code.
  function automatic logic [DIV_W-1:0] div_term(input logic [2:0] code);
    unique case (code)
      3'h0: div_term = 4'h0;
      3'h1: div_term = 4'h1;
      3'h2: div_term = 4'h2;
      3'h3: div_term = 4'h3;
      3'h4: div_term = 4'h5;
      3'h5: div_term = 4'h7;
      3'h6: div_term = 4'hb;
      3'h7: div_term = 4'hf;
    endcase
  endfunction : div_term

  function automatic pfs_clk_cfg_t frq_fields(input logic [15:0] word);
    frq_fields.freq_range_select  = word[FRQ_FREQ_RANGE_SELECT_BIT];
    frq_fields.clock_out_enable   = word[FRQ_CKOE_BIT];
    frq_fields.pll1_multiplier    = word[FRQ_STC_LSB +: FLD_W];
    frq_fields.internal_divider   = word[FRQ_IFC_LSB +: FLD_W];
    frq_fields.peripheral_divider = word[FRQ_PFC_LSB +: FLD_W];
  endfunction : frq_fields

endpackage : pfs_pkg

// File: verification/pfs_stabilizer_sva.sv
// Concurrent checks on the ports of the PLL frequency-change stabilizer.
module pfs_stabilizer_sva
  import pfs_pkg::*;
#(
  parameter int N_MOD = 4
) (
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [2:0]       hsize,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  input wire logic             sleep_req,
  input wire logic [N_MOD-1:0] module_stop,
  input wire logic             cpu_halt,
  input wire logic             internal_clk_en,
  input wire logic [N_MOD-1:0] module_clk_en,
  input wire logic             ckio_out,
  input wire logic             ckio_oe,
  input wire logic             overflow_output
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------
  // Bus
  // ----------
  ahb_wait_a: assert property (
    hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout) else $error("wait state wrong");
  okay_resp_a: assert property (hresp == HRESP_OKAY) else $error("response not OKAY");
  rdata_upper_a: assert property (hrdata[31:16] == 16'h0000) else $error("hrdata upper set");

  // ----------
  // Clock control
  // ----------
  // A halt that lags a frequency write would let the processor run on unstable clocks.
  halt_rise_a: assert property (
    hsel && htrans[1] && hready && hwrite && hsize == HSIZE_WORD && haddr == FRQ_CTL_ADDR
      && !cpu_halt |-> ##[2:4] cpu_halt) else $error("no halt after frequency write");
  halt_gate_a: assert property (
    cpu_halt && $past(cpu_halt) |-> !internal_clk_en) else $error("internal clock while halted");
  halt_no_ovf_a: assert property (
    cpu_halt |-> !overflow_output) else $error("overflow output during halt");
  ovf_pulse_a: assert property (
    overflow_output |=> !overflow_output) else $error("overflow output too long");
  ckio_off_a: assert property (
    !ckio_oe && !$past(ckio_oe) |-> !ckio_out) else $error("clock out while disabled");
  module_gate_a: assert property (
    (module_clk_en & $past(module_stop)) == '0) else $error("stopped module clocked");
  sleep_gate_a: assert property (
    sleep_req && $past(sleep_req) |-> !internal_clk_en) else $error("internal clock in sleep");
endmodule : pfs_stabilizer_sva

bind pfs_stabilizer pfs_stabilizer_sva #(.N_MOD(N_MOD)) sva_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .sleep_req(sleep_req), .module_stop(module_stop), .cpu_halt(cpu_halt),
  .internal_clk_en(internal_clk_en), .module_clk_en(module_clk_en), .ckio_out(ckio_out),
  .ckio_oe(ckio_oe), .overflow_output(overflow_output));

// File: verification/tb_top.sv
// Self-checking bench for the PLL frequency-change stabilizer.
module tb_top
  import pfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Signals and instance
  // ----------
  logic         hclk, hresetn, hsel, hwrite, sleep_req, standby_req, wake_irq;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [3:0]   module_stop, module_clk_en;
  logic         hreadyout, hresp, cpu_halt, internal_clk_en, bus_clk_en;
  logic         peripheral_clk_en, ckio_out, ckio_oe, overflow_output;
  pfs_clk_cfg_t clk_cfg;
  int           failures, checks_done, n, k;
  // A single slave drives the bus ready itself.
  wire logic    hready = hreadyout;

  initial hclk = 1'b0;
  always #2 hclk = ~hclk;

  pfs_stabilizer dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sleep_req(sleep_req), .standby_req(standby_req),
    .wake_irq(wake_irq), .module_stop(module_stop), .cpu_halt(cpu_halt),
    .internal_clk_en(internal_clk_en), .bus_clk_en(bus_clk_en),
    .peripheral_clk_en(peripheral_clk_en), .module_clk_en(module_clk_en), .clk_cfg(clk_cfg),
    .ckio_out(ckio_out), .ckio_oe(ckio_oe), .overflow_output(overflow_output));
  // ----------
  // Tasks
  // ----------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_rdy();
    for (int i = 0; i < 16 && hready !== 1'b1; i++) @(posedge hclk);
    // A slave that never answers must not let the run pass silently.
    if (hready !== 1'b1) chk("hready", 32'h0000_0001, 32'h0000_0000);
  endtask : wait_rdy

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    @(posedge hclk);
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    wait_rdy();
    rd = hrdata;
  endtask : ahb

  task automatic wait_until(ref logic s, input logic v, input int lim);
    for (n = 0; n < lim && s !== v; n++) @(posedge hclk);
    if (n == lim) chk("wait", 32'h0000_0001, 32'h0000_0000);
  endtask : wait_until

  task automatic count_hi(ref logic s, input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge hclk);
      n += int'(s === 1'b1);
    end
  endtask : count_hi

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // ----------
  // Tests
  // ----------
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, sleep_req, standby_req, wake_irq} = 5'h00;
    {haddr, hwdata, htrans, hsize, module_stop} = '0;
    failures = 0;
    checks_done = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("cfg", {21'h0, 1'b1, 1'b0, 3'h2, 3'h0, 3'h4}, {21'h0, clk_cfg});
    ahb(1'b0, FRQ_CTL_ADDR, 32'h0); chk("frq", 32'h0000_120c, rd);
    ahb(1'b0, WDT_CSR_ADDR, 32'h0); chk("csr", 32'h0, {24'h0, rd[7:0]});
    ahb(1'b1, 32'h0000_0100, 32'h0000_5aff);
    ahb(1'b0, 32'h0000_0100, 32'h0); chk("unmapped", 32'h0, rd);
    chk("oe", 32'h0, {31'h0, ckio_oe});
    $display("test reset done");
    ahb(1'b1, WDT_CSR_ADDR, 32'h0000_001e);
    ahb(1'b0, WDT_CSR_ADDR, 32'h0); chk("csr_nokey", 32'h0, {24'h0, rd[7:0]});
    ahb(1'b1, WDT_CNT_ADDR, 32'h0000_00ad);
    ahb(1'b0, WDT_CNT_ADDR, 32'h0); chk("cnt_nokey", 32'h0, {24'h0, rd[7:0]});
    ahb(1'b1, WDT_CNT_ADDR, 32'h0000_5aad);
    repeat (50) @(posedge hclk);
    ahb(1'b0, WDT_CNT_ADDR, 32'h0); chk("cnt_hold", 32'had, {24'h0, rd[7:0]});
    $display("test keys done");
    // Clock select 0 keeps the stabilization wait to a few peripheral ticks.
    ahb(1'b1, WDT_CSR_ADDR, 32'h0000_a500);
    ahb(1'b1, WDT_CNT_ADDR, 32'h0000_5afd);
    ahb(1'b1, FRQ_CTL_ADDR, 32'h0000_0801);
    wait_until(cpu_halt, 1'b1, 8); chk("halt", 32'h1, {31'h0, cpu_halt});
    wait_until(cpu_halt, 1'b0, 400); chk("halt_len", 32'h1, {31'h0, n >= 10 && n <= 60});
    repeat (4) @(posedge hclk);
    chk("cfg_new", {21'h0, 1'b0, 1'b1, 3'h0, 3'h0, 3'h1}, {21'h0, clk_cfg});
    chk("oe_on", 32'h1, {31'h0, ckio_oe});
    count_hi(peripheral_clk_en, 20); chk("pclk", 32'd10, n);
    count_hi(internal_clk_en, 20); chk("iclk", 32'd20, n);
    count_hi(bus_clk_en, 20); chk("bclk", 32'd10, n);
    count_hi(ckio_out, 20); chk("ckio", 32'd10, n);
    ahb(1'b0, FRQ_CTL_ADDR, 32'h0); chk("frq_new", 32'h0000_0801, rd);
    $display("test frequency change done");
    // Code 110 makes one count last 4096 peripheral ticks, about 8192 cycles here.
    ahb(1'b1, WDT_CNT_ADDR, 32'h0000_5aff);
    ahb(1'b1, WDT_CSR_ADDR, 32'h0000_a5c6);
    wait_until(overflow_output, 1'b1, 9000);
    chk("wdt_time", 32'h1, {31'h0, n >= 8170 && n <= 8215});
    ahb(1'b0, WDT_CSR_ADDR, 32'h0); chk("csr_wovf", 32'he6, {24'h0, rd[7:0]});
    ahb(1'b1, WDT_CNT_ADDR, 32'h0000_5afe);
    ahb(1'b1, WDT_CSR_ADDR, 32'h0000_a580);
    count_hi(overflow_output, 40); chk("no_ovf_out", 32'h0, n);
    ahb(1'b0, WDT_CSR_ADDR, 32'h0); chk("csr_iovf", 32'h90, {24'h0, rd[7:0]});
    ahb(1'b1, WDT_CSR_ADDR, 32'h0000_a500);
    $display("test timer modes done");
    sleep_req <= 1'b1;
    module_stop <= 4'h1;
    repeat (2) @(posedge hclk);
    count_hi(internal_clk_en, 20); chk("sleep_iclk", 32'h0, n);
    k = 0;
    repeat (20) begin
      @(posedge hclk);
      k += int'(module_clk_en[0] === 1'b1) + 100 * int'(module_clk_en[1] === 1'b1);
    end
    chk("module_en", 32'd1000, k);
    sleep_req <= 1'b0;
    module_stop <= 4'h0;
    ahb(1'b1, WDT_CNT_ADDR, 32'h0000_5af0);
    standby_req <= 1'b1;
    @(posedge hclk);
    standby_req <= 1'b0;
    repeat (3) @(posedge hclk);
    count_hi(peripheral_clk_en, 20); chk("stby_pclk", 32'h0, n);
    chk("stby_halt", 32'h1, {31'h0, cpu_halt});
    wake_irq <= 1'b1;
    @(posedge hclk);
    wake_irq <= 1'b0;
    wait_until(cpu_halt, 1'b0, 2000);
    chk("cfg_kept", {21'h0, 1'b0, 1'b1, 3'h0, 3'h0, 3'h1}, {21'h0, clk_cfg});
    $display("test power down done");
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge hclk);
    failures++;
    report_and_stop();
  end
endmodule : tb_top
